/* core/uart_irq_ctrl.sv */
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

module uart_irq_ctrl #(
  parameter int FIFO_DEPTH = 64,
  parameter int CNT_W = 7
) (
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // uart event sources, same clock
  input wire logic cts_change,
  input wire logic rx_timeout,
  input wire logic framing_err,
  input wire logic parity_err,
  input wire logic break_err,
  input wire logic overrun_err,
  input wire logic flow_off,
  input wire logic tx_empty,
  // fifo fill levels in entries
  input wire logic [CNT_W-1:0] tx_fifo_count,
  input wire logic [CNT_W-1:0] rx_fifo_count,
  // combined interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] tx_level;
    logic [2:0] rx_level;
    logic [12:0] mask;
    logic [12:0] raw;
    logic [31:0] rdata;
  } state_type;

  state_type state_q;
  state_type state_d;

  logic [CNT_W-1:0] tx_free;
  logic tx_reached;
  logic rx_reached;
  logic [12:0] set_vec;
  logic [12:0] masked;
  logic setup_rd;
  logic access;
  logic wr_en;
  logic addr_ok;

  // geometry guard at elaboration
  if (FIFO_DEPTH < 1 || CNT_W != $clog2(FIFO_DEPTH + 1)) begin : g_bad_geometry
    $error("uart_irq_ctrl: bad FIFO_DEPTH or CNT_W");
  end

  // ----------------------------------------------------------------
  // fifo threshold detection
  // ----------------------------------------------------------------
  // empty entries of the tx fifo
  assign tx_free = CNT_W'(FIFO_DEPTH) - tx_fifo_count;

  fifo_level_compare #(
    .DEPTH(FIFO_DEPTH),
    .CNT_W(CNT_W)
  ) u_tx_cmp (
    .code(state_q.tx_level),
    .level(tx_free),
    .reached(tx_reached)
  );

  fifo_level_compare #(
    .DEPTH(FIFO_DEPTH),
    .CNT_W(CNT_W)
  ) u_rx_cmp (
    .code(state_q.rx_level),
    .level(rx_fifo_count),
    .reached(rx_reached)
  );

  // event vector at status bit positions
  always_comb begin
    set_vec = 13'h0000;
    set_vec[uart_irq_pkg::SRC_CTS] = cts_change;
    set_vec[uart_irq_pkg::SRC_RX] = rx_reached;
    set_vec[uart_irq_pkg::SRC_TX] = tx_reached;
    set_vec[uart_irq_pkg::SRC_RX_TIMEOUT] = rx_timeout;
    set_vec[uart_irq_pkg::SRC_FRAMING] = framing_err;
    set_vec[uart_irq_pkg::SRC_PARITY] = parity_err;
    set_vec[uart_irq_pkg::SRC_BREAK] = break_err;
    set_vec[uart_irq_pkg::SRC_OVERRUN] = overrun_err;
    set_vec[uart_irq_pkg::SRC_FLOW_OFF] = flow_off;
    set_vec[uart_irq_pkg::SRC_TX_EMPTY] = tx_empty;
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // zero wait states; unmapped addresses answer with an error
  assign access = psel & penable;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr_en = access & pwrite;
  assign addr_ok = (paddr == uart_irq_pkg::OFS_THRESHOLD_SELECT) |
                   (paddr == uart_irq_pkg::OFS_ENABLE_MASK) |
                   (paddr == uart_irq_pkg::OFS_RAW_STATUS) |
                   (paddr == uart_irq_pkg::OFS_MASKED_STATUS) |
                   (paddr == uart_irq_pkg::OFS_CLEAR);
  assign pready = 1'b1;
  assign pslverr = access & ~addr_ok;
  assign prdata = state_q.rdata;

  // masked status and combined output
  assign masked = state_q.raw & state_q.mask;
  assign irq = |masked;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    // read data latched in the setup cycle
    if (setup_rd) begin
      case (paddr)
        uart_irq_pkg::OFS_THRESHOLD_SELECT: begin
          state_d.rdata = {26'h0000000, state_q.rx_level, state_q.tx_level};
        end
        uart_irq_pkg::OFS_ENABLE_MASK: begin
          state_d.rdata = {19'h00000, state_q.mask};
        end
        uart_irq_pkg::OFS_RAW_STATUS: begin
          state_d.rdata = {19'h00000, state_q.raw};
        end
        uart_irq_pkg::OFS_MASKED_STATUS: begin
          state_d.rdata = {19'h00000, masked};
        end
        default: begin
          state_d.rdata = 32'h00000000;
        end
      endcase
    end
    // register writes
    if (wr_en && paddr == uart_irq_pkg::OFS_THRESHOLD_SELECT) begin
      state_d.tx_level = pwdata[uart_irq_pkg::TX_LEVEL_LO +: uart_irq_pkg::LEVEL_W];
      state_d.rx_level = pwdata[uart_irq_pkg::RX_LEVEL_LO +: uart_irq_pkg::LEVEL_W];
    end
    if (wr_en && paddr == uart_irq_pkg::OFS_ENABLE_MASK) begin
      state_d.mask = pwdata[12:0] & uart_irq_pkg::SRC_VALID;
    end
    if (wr_en && paddr == uart_irq_pkg::OFS_CLEAR) begin
      state_d.raw = state_q.raw & ~pwdata[12:0];
    end
    // a new event wins over a clear in the same cycle
    state_d.raw = state_d.raw | (set_vec & uart_irq_pkg::SRC_VALID);
    if (rst) begin
      state_d.tx_level = uart_irq_pkg::TX_LEVEL_RST;
      state_d.rx_level = uart_irq_pkg::RX_LEVEL_RST;
      state_d.mask = uart_irq_pkg::MASK_RST;
      state_d.raw = uart_irq_pkg::RAW_RST;
      state_d.rdata = 32'h00000000;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    state_q <= state_d;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_tx_level_reset: assert property (
    $past(rst) |-> state_q.tx_level == uart_irq_pkg::TX_LEVEL_RST)
    else $error("tx level not at reset value");

  a_rx_level_reset: assert property (
    $past(rst) |-> state_q.rx_level == uart_irq_pkg::RX_LEVEL_RST && state_q.mask == 13'h0000)
    else $error("rx level or mask not at reset value");

  a_level_write: assert property (
    wr_en && paddr == uart_irq_pkg::OFS_THRESHOLD_SELECT
    |=> {state_q.rx_level, state_q.tx_level} == $past(pwdata[5:0]))
    else $error("level write not stored");

  a_mask_write_read: assert property (
    wr_en && paddr == uart_irq_pkg::OFS_ENABLE_MASK
    ##1 setup_rd && paddr == uart_irq_pkg::OFS_ENABLE_MASK
    |=> prdata == {19'h00000, $past(pwdata[12:0], 2) & uart_irq_pkg::SRC_VALID})
    else $error("mask read back differs from write");

  a_masked_read: assert property (
    setup_rd && paddr == uart_irq_pkg::OFS_MASKED_STATUS
    |=> prdata == {19'h00000, $past(state_q.raw & state_q.mask)})
    else $error("masked status read wrong");

  a_clear_bits: assert property (
    wr_en && paddr == uart_irq_pkg::OFS_CLEAR
    |=> (state_q.raw & $past(pwdata[12:0] & ~set_vec)) == 13'h0000)
    else $error("clear did not remove pending bit");

  a_set_wins: assert property (
    (set_vec & uart_irq_pkg::SRC_VALID) != 13'h0000
    |=> (state_q.raw & $past(set_vec & uart_irq_pkg::SRC_VALID))
        == $past(set_vec & uart_irq_pkg::SRC_VALID))
    else $error("event lost");

  a_rx_threshold: assert property (
    rx_reached |=> state_q.raw[uart_irq_pkg::SRC_RX])
    else $error("rx threshold not raised");

  a_tx_threshold: assert property (
    tx_reached |=> state_q.raw[uart_irq_pkg::SRC_TX])
    else $error("tx threshold not raised");

  a_mask_gates_irq: assert property (
    irq == ((state_q.raw & state_q.mask) != 13'h0000))
    else $error("irq does not follow masked status");

  // register hold, reserved bits and quiet reset
  a_level_hold: assert property (
    !rst && !(wr_en && paddr == uart_irq_pkg::OFS_THRESHOLD_SELECT)
    |=> $stable(state_q.tx_level) && $stable(state_q.rx_level))
    else $error("levels changed without a write");

  a_mask_hold: assert property (
    !rst && !(wr_en && paddr == uart_irq_pkg::OFS_ENABLE_MASK)
    |=> $stable(state_q.mask))
    else $error("mask changed without a write");

  a_raw_sticky: assert property (
    !rst && !(wr_en && paddr == uart_irq_pkg::OFS_CLEAR)
    |=> (state_q.raw & $past(state_q.raw)) == $past(state_q.raw))
    else $error("pending bit dropped without a clear");

  a_irq_after_mask: assert property (
    wr_en && paddr == uart_irq_pkg::OFS_ENABLE_MASK
    |=> irq == ((state_q.raw & $past(pwdata[12:0]) & uart_irq_pkg::SRC_VALID) != 13'h0000))
    else $error("irq does not follow written mask");

  a_level_reserved_zero: assert property (
    setup_rd && paddr == uart_irq_pkg::OFS_THRESHOLD_SELECT
    |=> prdata[31:6] == 26'h0000000)
    else $error("threshold select reserved bits not zero");

  a_mask_reserved_zero: assert property (
    setup_rd && paddr == uart_irq_pkg::OFS_ENABLE_MASK
    |=> prdata[31:13] == 19'h00000)
    else $error("mask reserved bits not zero");

  a_masked_in_mask: assert property (
    setup_rd && paddr == uart_irq_pkg::OFS_MASKED_STATUS
    |=> (prdata[12:0] & ~$past(state_q.mask)) == 13'h0000)
    else $error("masked status shows a disabled source");

  a_reset_quiet: assert property (
    $past(rst) |-> !irq && state_q.raw == uart_irq_pkg::RAW_RST)
    else $error("interrupt pending right after reset");

  // threshold encodings, worked out by multiplication instead of shifts
  a_rx_fraction: assert property (
    state_q.rx_level < uart_irq_pkg::LEVEL_THREE_QUARTER
    |-> rx_reached == (int'(rx_fifo_count) * 64 >= FIFO_DEPTH * (1 << state_q.rx_level)))
    else $error("rx fraction trigger wrong");

  a_tx_fraction: assert property (
    state_q.tx_level < uart_irq_pkg::LEVEL_THREE_QUARTER
    |-> tx_reached == ((FIFO_DEPTH - int'(tx_fifo_count)) * 64 >= FIFO_DEPTH * (1 << state_q.tx_level)))
    else $error("tx fraction trigger wrong");

  a_rx_three_quarter: assert property (
    state_q.rx_level == uart_irq_pkg::LEVEL_THREE_QUARTER
    |-> rx_reached == (int'(rx_fifo_count) * 4 >= FIFO_DEPTH * 3))
    else $error("rx three quarter trigger wrong");

  a_tx_three_quarter: assert property (
    state_q.tx_level == uart_irq_pkg::LEVEL_THREE_QUARTER
    |-> tx_reached == ((FIFO_DEPTH - int'(tx_fifo_count)) * 4 >= FIFO_DEPTH * 3))
    else $error("tx three quarter trigger wrong");

endmodule // uart_irq_ctrl

/* core/uart_irq_pkg.sv */
package uart_irq_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_THRESHOLD_SELECT = 12'h034;
  localparam logic [11:0] OFS_ENABLE_MASK = 12'h038;
  localparam logic [11:0] OFS_RAW_STATUS = 12'h03C;
  localparam logic [11:0] OFS_MASKED_STATUS = 12'h040;
  localparam logic [11:0] OFS_CLEAR = 12'h044;

  // ----------------------------------------------------------------
  // threshold select fields
  // ----------------------------------------------------------------
  localparam int TX_LEVEL_LO = 0;
  localparam int RX_LEVEL_LO = 3;
  localparam int LEVEL_W = 3;
  localparam logic [2:0] TX_LEVEL_RST = 3'h2;
  localparam logic [2:0] RX_LEVEL_RST = 3'h2;

  // threshold codes: 0..5 are 1/64 doubling up to 1/2, then 3/4
  localparam logic [2:0] LEVEL_HALF = 3'h5;
  localparam logic [2:0] LEVEL_THREE_QUARTER = 3'h6;
  localparam logic [2:0] LEVEL_RESERVED = 3'h7;
  localparam logic [2:0] LEVEL_LOG_FINEST = 3'h6;

  // ----------------------------------------------------------------
  // interrupt source bit positions
  // ----------------------------------------------------------------
  localparam int SRC_W = 13;
  localparam int SRC_CTS = 1;
  localparam int SRC_RX = 4;
  localparam int SRC_TX = 5;
  localparam int SRC_RX_TIMEOUT = 6;
  localparam int SRC_FRAMING = 7;
  localparam int SRC_PARITY = 8;
  localparam int SRC_BREAK = 9;
  localparam int SRC_OVERRUN = 10;
  localparam int SRC_FLOW_OFF = 11;
  localparam int SRC_TX_EMPTY = 12;
  localparam logic [12:0] SRC_VALID = 13'h1FF2;
  localparam logic [12:0] MASK_RST = 13'h0000;
  localparam logic [12:0] RAW_RST = 13'h0000;

endpackage

/* core/fifo_level_compare.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------------
// fifo fraction comparator
// ------------------------------------------------------------------
module fifo_level_compare #(
  parameter int DEPTH = 64,
  parameter int CNT_W = 7
) (
  input wire logic [2:0] code,
  input wire logic [CNT_W-1:0] level,
  output logic reached
);

  logic [CNT_W+7:0] lvl_x;
  logic [CNT_W+7:0] dep_x;
  logic [2:0] shift;

  // geometry guard at elaboration
  if (DEPTH < 1 || CNT_W != $clog2(DEPTH + 1)) begin : g_bad_geometry
    $error("fifo_level_compare: bad DEPTH or CNT_W");
  end

  // level/depth >= fraction, compared without division
  always_comb begin
    lvl_x = {8'h00, level};
    dep_x = (CNT_W + 8)'(DEPTH);
    shift = uart_irq_pkg::LEVEL_LOG_FINEST - code;
    reached = 1'b0;
    case (code)
      uart_irq_pkg::LEVEL_THREE_QUARTER: begin
        reached = (lvl_x << 2) >= ((dep_x << 1) + dep_x);
      end
      uart_irq_pkg::LEVEL_RESERVED: begin
        reached = 1'b0; // reserved code never triggers
      end
      default: begin
        reached = (lvl_x << shift) >= dep_x;
      end
    endcase
  end

endmodule // fifo_level_compare

/* verification/irq_sink_model.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// interrupt controller stand-in
// ------------------------------------------------------------
module irq_sink_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic irq,
  output logic irq_seen
);
  // level line latched each edge, as a controller would
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_seen <= 1'b0;
    end else begin
      irq_seen <= irq;
    end
  end
endmodule // irq_sink_model

/* verification/tb.sv */
`timescale 1ns/1ps

module tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, irq_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] ev;
  logic [6:0] txc, rxc;
  logic [32:0] expq[$];
  logic [32:0] got;
  int fails, compares, cyc;
  int pos[8] = '{1, 6, 7, 8, 9, 10, 11, 12};

  uart_irq_ctrl dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cts_change(ev[0]), .rx_timeout(ev[1]), .framing_err(ev[2]),
    .parity_err(ev[3]), .break_err(ev[4]), .overrun_err(ev[5]), .flow_off(ev[6]),
    .tx_empty(ev[7]), .tx_fifo_count(txc), .rx_fifo_count(rxc), .irq(irq));

  irq_sink_model sink_u (.clk(clk), .rst(rst), .irq(irq), .irq_seen(irq_seen));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // apb transfer, held until pready is seen at an edge; k keeps psel for a setup at once
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic k);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    penable <= 1'b0;
    if (!k) begin
      psel <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 1'b0);
  endtask

  // expected read noted in the queue first
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e);
    expq.push_back({e, d});
    apb(a, 1'b0, 32'h0, 1'b0);
  endtask

  // write, then read back with the setup right after the access
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    apb(a, 1'b1, d, 1'b1);
    rd(a, e, 1'b0);
  endtask

  // one read result against its note
  task automatic chk_rd(input logic [32:0] g, input logic [32:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t read %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_irq(input logic e);
    compares++;
    if (irq_seen !== e) begin
      fails++;
      $display("BAD %0t irq %b exp %b", $time, irq_seen, e);
    end
  endtask

  // fill of rx, or emptiness of tx, set to n entries
  task automatic set_lvl(input int s, input int n);
    if (s == 1) txc <= 7'(64 - n);
    else rxc <= 7'(n);
  endtask

  // read monitor and run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (psel && penable && pready && !pwrite) begin
      got = expq.pop_front();
      chk_rd({pslverr, prdata}, got);
    end
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    logic [2:0] c1, c2;
    int thr;
    fails = 0;
    compares = 0;
    cyc = 0;
    rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ev = 8'h00;
    txc = 7'h40;
    rxc = 7'h00;
    void'($urandom(32'h318B4EF8));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values and unmapped place
    rd(uart_irq_pkg::OFS_THRESHOLD_SELECT, 32'h12, 1'b0);
    rd(uart_irq_pkg::OFS_ENABLE_MASK, 32'h0, 1'b0);
    rd(12'h100, 32'h0, 1'b1);
    repeat (4) begin
      c1 = 3'($urandom_range(6));
      c2 = 3'($urandom_range(6));
      wr_rd(uart_irq_pkg::OFS_THRESHOLD_SELECT, {26'h0, c2, c1}, {26'h0, c2, c1});
    end
    wr_rd(uart_irq_pkg::OFS_ENABLE_MASK, 32'hFFFFFFFF, 32'h1FF2);
    chk_irq(1'b0);
    // each event source: masked off, then enabled, then cleared
    for (int i = 0; i < 8; i++) begin
      wr(uart_irq_pkg::OFS_ENABLE_MASK, 32'h0);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev <= 8'h00;
      repeat (2) @(posedge clk);
      chk_irq(1'b0);
      rd(uart_irq_pkg::OFS_RAW_STATUS, 32'h1 << pos[i], 1'b0);
      rd(uart_irq_pkg::OFS_MASKED_STATUS, 32'h0, 1'b0);
      wr(uart_irq_pkg::OFS_ENABLE_MASK, 32'h1 << pos[i]);
      @(posedge clk);
      chk_irq(1'b1);
      rd(uart_irq_pkg::OFS_MASKED_STATUS, 32'h1 << pos[i], 1'b0);
      wr(uart_irq_pkg::OFS_CLEAR, 32'h1 << pos[i]);
      @(posedge clk);
      chk_irq(1'b0);
      rd(uart_irq_pkg::OFS_RAW_STATUS, 32'h0, 1'b0);
    end
    // thresholds: one entry short, then exactly reached
    wr(uart_irq_pkg::OFS_ENABLE_MASK, 32'h30);
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 7; c++) begin
        thr = (c == 6) ? 48 : (1 << c);
        wr(uart_irq_pkg::OFS_THRESHOLD_SELECT, (s == 1) ? 32'(c) : 32'(c << 3));
        set_lvl(s, thr - 1);
        wr(uart_irq_pkg::OFS_CLEAR, 32'h30);
        rd(uart_irq_pkg::OFS_RAW_STATUS, 32'h0, 1'b0);
        chk_irq(1'b0);
        set_lvl(s, thr);
        repeat (2) @(posedge clk);
        rd(uart_irq_pkg::OFS_RAW_STATUS, 32'h10 << s, 1'b0);
        chk_irq(1'b1);
        set_lvl(s, 0);
        wr(uart_irq_pkg::OFS_CLEAR, 32'h30);
      end
    end
    // reset in mid-run brings back the register defaults
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(uart_irq_pkg::OFS_THRESHOLD_SELECT, 32'h12, 1'b0);
    rd(uart_irq_pkg::OFS_ENABLE_MASK, 32'h0, 1'b0);
    chk_irq(1'b0);
    tally_and_finish();
  end
endmodule // tb
